// ### core/eeb_defines.svh
// constants of the external bus and interrupt front end
// assumes a single clock that is the oscillator input itself
//
// Summary of operation
// - flat 8192-byte space on thirteen address outputs
// - address on its own outputs, all thirteen valid each bus cycle
// - eight-bit two-way data bus, never shared with address
// - page zero holds I/O and timer, 48-byte external window, 176 RAM
// - everything above page zero, 7936 bytes, is external space
// - former ROM ranges go external; no internal ROM answers
// - chip select low for every external RAM or I/O access
// - chip select stays high on the seven unused I/O addresses
// - read output low on every read, high otherwise
// - internal RAM and I/O reads are also driven onto the data bus
// - write strobe low on external writes with data valid
// - data strobe pulses on every read and write cycle
// - data strobe runs at half oscillator rate outside wait and stop
// - fetch status high during each opcode fetch cycle
// - reduced-pin variant: select is output enable, read is enable
// - reduced-pin variant: write, data strobe, fetch outputs absent
// - interrupt sense fixed at build: edge only or edge and level
// - edge-and-level build: edge or held low raises a request
// - a qualifying low sets the request latch
// - pending request waits for the current instruction to end
// - at boundary, latch set and mask clear start interrupt sequence
// - internal clocks are the oscillator divided by two
`ifndef EEB_DEFINES_SVH
`define EEB_DEFINES_SVH

`define EEB_ADDR_W      13
`define EEB_DATA_W      8
`define EEB_SPACE_BYTES 8192
`define EEB_PAGE_MSB    12
`define EEB_PAGE_LSB    8
`define EEB_IO_LAST     8'h1F
`define EEB_WIN_FIRST   8'h20
`define EEB_WIN_LAST    8'h4F
`define EEB_RAM_FIRST   8'h50
`define EEB_RAM_BYTES   176
`define EEB_OSC_DIV     2
`define EEB_IO_UNUSED   32'hE000_E040
`define EEB_DATA_RST    8'h00
`define EEB_ADDR_RST    13'h0000

`endif

// ### core/eeb_pkg.sv
// types shared by the external bus front end
// assumes eeb_defines.svh is on the include path
package eeb_pkg;

  // one access offered by the cpu core
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        write;
    logic        fetch;
  } eeb_req_t;

  // where an address lands
  typedef enum logic [3:0] {
    EEB_TGT_IO     = 4'b0001,
    EEB_TGT_UNUSED = 4'b0010,
    EEB_TGT_RAM    = 4'b0100,
    EEB_TGT_EXT    = 4'b1000
  } eeb_target_t;

  // bus cycle sequencer
  typedef enum logic [2:0] {
    EEB_ST_IDLE = 3'b001,
    EEB_ST_ADDR = 3'b010,
    EEB_ST_STRB = 3'b100
  } eeb_state_t;

endpackage

// ### core/eeb_bus_irq.sv
// external memory bus and interrupt request front end
// assumes clk is the oscillator; cpu core offers one access at a time
`timescale 1ns/1ps
`include "eeb_defines.svh"

module eeb_bus_irq #(
  parameter bit          REDUCED_PINS   = 1'b0,
  parameter bit          EDGE_AND_LEVEL = 1'b1,
  parameter logic [31:0] IO_UNUSED      = `EEB_IO_UNUSED,
  parameter int          RAM_BYTES      = `EEB_RAM_BYTES
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              cpu_req,
  input  wire eeb_pkg::eeb_req_t cpu_req_info,
  output logic                   cpu_ready,
  output logic                   cpu_ack,
  output logic [7:0]             cpu_rdata,
  input  wire logic              low_power,
  output logic [12:0]            address_lines,
  input  wire logic [7:0]        data_lines_in,
  output logic [7:0]             data_lines_out,
  output logic                   data_lines_oe,
  output logic                   chip_select_n,
  output logic                   read_n,
  output logic                   write_n,
  output logic                   data_strobe,
  output logic                   fetch_status,
  output logic                   io_write,
  output logic [4:0]             io_index,
  output logic [7:0]             io_wdata,
  input  wire logic [7:0]        io_rdata,
  input  wire logic              irq_n,
  input  wire logic              insn_boundary,
  input  wire logic              irq_mask,
  output logic                   irq_take,
  output logic                   irq_pending
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  eeb_pkg::eeb_req_t   req_q;
  eeb_pkg::eeb_req_t   req_d;
  eeb_pkg::eeb_target_t tgt;
  logic [7:0]          page_off;

  assign page_off = req_q.addr[7:0];

  // page zero splits into I/O, window and RAM; the rest is external
  always_comb begin
    if (req_q.addr[`EEB_PAGE_MSB:`EEB_PAGE_LSB] != 5'h00) begin
      tgt = eeb_pkg::EEB_TGT_EXT;
    end else if (page_off <= `EEB_IO_LAST) begin
      if (IO_UNUSED[page_off[4:0]]) begin
        tgt = eeb_pkg::EEB_TGT_UNUSED;
      end else begin
        tgt = eeb_pkg::EEB_TGT_IO;
      end
    end else if (page_off <= `EEB_WIN_LAST) begin
      tgt = eeb_pkg::EEB_TGT_EXT;
    end else begin
      tgt = eeb_pkg::EEB_TGT_RAM;
    end
  end

  // ****************************************************************
  // internal ram
  // ****************************************************************
  logic [7:0] ram_q [RAM_BYTES];
  logic [7:0] ram_idx;
  logic       ram_we;
  logic [7:0] int_rdata;

  assign ram_idx = page_off - `EEB_RAM_FIRST;

  // no reset on the array: contents are undefined at power up, as on
  // a real part, which also keeps it out of the reset tree
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_q[ram_idx] <= req_q.wdata;
    end
  end

  // read data of the internal targets, zero for unused I/O slots
  always_comb begin
    case (tgt)
      eeb_pkg::EEB_TGT_RAM: int_rdata = ram_q[ram_idx];
      eeb_pkg::EEB_TGT_IO:  int_rdata = io_rdata;
      default:              int_rdata = `EEB_DATA_RST;
    endcase
  end

  // ****************************************************************
  // clock divider and bus cycle sequencer
  // ****************************************************************
  logic                phase_q;
  logic                phase_d;
  eeb_pkg::eeb_state_t state_q;
  eeb_pkg::eeb_state_t state_d;
  logic                accept;

  // a cycle starts only on the second half of the divided clock, so
  // address and strobe phases always line up with data_strobe
  assign accept = cpu_req & cpu_ready;

  always_comb begin
    phase_d = ~phase_q;
    state_d = state_q;
    req_d   = req_q;
    case (state_q)
      eeb_pkg::EEB_ST_IDLE: begin
        if (accept) begin
          state_d = eeb_pkg::EEB_ST_ADDR;
          req_d   = cpu_req_info;
        end
      end
      eeb_pkg::EEB_ST_ADDR: begin
        state_d = eeb_pkg::EEB_ST_STRB;
      end
      eeb_pkg::EEB_ST_STRB: begin
        // back to back cycles keep the bus busy without an idle gap
        if (accept) begin
          state_d = eeb_pkg::EEB_ST_ADDR;
          req_d   = cpu_req_info;
        end else begin
          state_d = eeb_pkg::EEB_ST_IDLE;
        end
      end
      default: begin
        state_d = eeb_pkg::EEB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 1'b0;
      state_q <= eeb_pkg::EEB_ST_IDLE;
      req_q   <= '0;
    end else begin
      phase_q <= phase_d;
      state_q <= state_d;
      req_q   <= req_d;
    end
  end

  // ****************************************************************
  // pin outputs
  // ****************************************************************
  logic        ready_q, ready_d;
  logic        ack_q, ack_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [12:0] addr_q, addr_d;
  logic [7:0]  dout_q, dout_d;
  logic        doe_q, doe_d;
  logic        cs_n_q, cs_n_d;
  logic        rd_n_q, rd_n_d;
  logic        we_n_q, we_n_d;
  logic        ds_q, ds_d;
  logic        fs_q, fs_d;
  logic        iow_q, iow_d;
  logic        in_strb;
  logic        in_cycle;
  logic        is_ext;

  assign in_strb  = (state_d == eeb_pkg::EEB_ST_STRB);
  assign in_cycle = (state_d != eeb_pkg::EEB_ST_IDLE);
  assign is_ext   = (tgt == eeb_pkg::EEB_TGT_EXT);
  assign ram_we   = (state_q == eeb_pkg::EEB_ST_ADDR) & req_q.write
                    & (tgt == eeb_pkg::EEB_TGT_RAM);

  // every output is computed for the coming half period and then
  // registered, so the pins change together on one clock edge
  always_comb begin
    // ready rises with phase, so an accept edge is one where phase goes low
    ready_d = ~phase_q & ~low_power;
    ack_d   = (state_q == eeb_pkg::EEB_ST_STRB);
    rdata_d = rdata_q;
    if (state_q == eeb_pkg::EEB_ST_STRB && !req_q.write) begin
      rdata_d = is_ext ? data_lines_in : int_rdata;
    end
    addr_d  = req_d.addr;
    dout_d  = `EEB_DATA_RST;
    doe_d   = 1'b0;
    cs_n_d  = 1'b1;
    rd_n_d  = 1'b1;
    we_n_d  = 1'b1;
    fs_d    = 1'b0;
    iow_d   = 1'b0;
    // strobe free runs at half the oscillator rate unless asleep
    ds_d    = low_power ? 1'b0 : phase_d;
    if (in_cycle) begin
      // pins follow the request that will stand in the next cycle
      rd_n_d = req_d.write;
      fs_d   = req_d.fetch & ~req_d.write;
      if (state_d == eeb_pkg::EEB_ST_ADDR) begin
        ds_d = 1'b0;
      end else begin
        ds_d = 1'b1;
      end
    end
    if (state_q == eeb_pkg::EEB_ST_ADDR) begin
      // strobe half only: a back to back take must not reuse old decode
      cs_n_d = ~is_ext;
      if (req_q.write) begin
        dout_d = req_q.wdata;
        doe_d  = 1'b1;
        we_n_d = ~(in_strb & is_ext);
        iow_d  = in_strb & (tgt == eeb_pkg::EEB_TGT_IO);
      end else if (!is_ext && in_strb) begin
        dout_d = int_rdata;
        doe_d  = (tgt != eeb_pkg::EEB_TGT_UNUSED);
      end
    end
    if (state_q == eeb_pkg::EEB_ST_IDLE && in_cycle) begin
      // first half of a cycle: address settles before any select
      addr_d = req_d.addr;
    end
    // the reduced-pin variant drops the three extra outputs and
    // reuses select as output enable and read as chip enable
    if (REDUCED_PINS) begin
      we_n_d = 1'b1;
      ds_d   = 1'b0;
      fs_d   = 1'b0;
      cs_n_d = ~(is_ext & in_strb & ~req_q.write
                 & (state_q != eeb_pkg::EEB_ST_IDLE));
      rd_n_d = ~(in_cycle & is_ext
                 & (state_q != eeb_pkg::EEB_ST_IDLE));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_q <= 1'b0;
      ack_q   <= 1'b0;
      rdata_q <= `EEB_DATA_RST;
      addr_q  <= `EEB_ADDR_RST;
      dout_q  <= `EEB_DATA_RST;
      doe_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      rd_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      ds_q    <= 1'b0;
      fs_q    <= 1'b0;
      iow_q   <= 1'b0;
    end else begin
      ready_q <= ready_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      addr_q  <= addr_d;
      dout_q  <= dout_d;
      doe_q   <= doe_d;
      cs_n_q  <= cs_n_d;
      rd_n_q  <= rd_n_d;
      we_n_q  <= we_n_d;
      ds_q    <= ds_d;
      fs_q    <= fs_d;
      iow_q   <= iow_d;
    end
  end

  // io side data gets its own flops, so index and data line up with io_write
  logic [4:0] ioi_q, ioi_d;
  logic [7:0] iod_q, iod_d;

  always_comb begin
    ioi_d = req_q.addr[4:0];
    iod_d = req_q.wdata;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ioi_q <= 5'h00;
      iod_q <= `EEB_DATA_RST;
    end else begin
      ioi_q <= ioi_d;
      iod_q <= iod_d;
    end
  end

  assign cpu_ready      = ready_q;
  assign cpu_ack        = ack_q;
  assign cpu_rdata      = rdata_q;
  assign address_lines  = addr_q;
  assign data_lines_out = dout_q;
  assign data_lines_oe  = doe_q;
  assign chip_select_n  = cs_n_q;
  assign read_n         = rd_n_q;
  assign write_n        = we_n_q;
  assign data_strobe    = ds_q;
  assign fetch_status   = fs_q;
  assign io_write       = iow_q;
  assign io_index       = ioi_q;
  assign io_wdata       = iod_q;

  // ****************************************************************
  // external interrupt request
  // ****************************************************************
  logic irq_s1_q, irq_s1_d;
  logic irq_s2_q, irq_s2_d;
  logic irq_old_q, irq_old_d;
  logic latch_q, latch_d;
  logic take_q, take_d;
  logic sense;
  logic take_now;

  // two flops before anything looks at the pin; the first is read
  // only by the second to keep metastability contained
  always_comb begin
    irq_s1_d  = irq_n;
    irq_s2_d  = irq_s1_q;
    irq_old_d = irq_s2_q;
  end

  // the sense option is a build choice, not a run time bit
  assign sense = (irq_old_q & ~irq_s2_q)
                 | (EDGE_AND_LEVEL & ~irq_s2_q);

  // the core only asks at instruction boundaries, so the current
  // instruction always finishes before the sequence begins
  assign take_now = insn_boundary & latch_q & ~irq_mask;

  // a new qualifying low in the take cycle wins over the clear, so
  // no request is dropped
  always_comb begin
    latch_d = latch_q;
    if (take_now) begin
      latch_d = 1'b0;
    end
    if (sense) begin
      latch_d = 1'b1;
    end
    take_d = take_now;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_s1_q  <= 1'b1;
      irq_s2_q  <= 1'b1;
      irq_old_q <= 1'b1;
      latch_q   <= 1'b0;
      take_q    <= 1'b0;
    end else begin
      irq_s1_q  <= irq_s1_d;
      irq_s2_q  <= irq_s2_d;
      irq_old_q <= irq_old_d;
      latch_q   <= latch_d;
      take_q    <= take_d;
    end
  end

  assign irq_take    = take_q;
  assign irq_pending = latch_q;

endmodule

// ### verification/eeb_bus_irq_sva.sv
// assertion checker for the external bus and interrupt front end
// assumes the full-pin build; sees only the ports of eeb_bus_irq
`timescale 1ns/1ps
module eeb_bus_irq_sva #(
  parameter logic [31:0] IO_UNUSED = 32'h0000_0000
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              cpu_req,
  input wire eeb_pkg::eeb_req_t cpu_req_info,
  input wire logic              cpu_ready,
  input wire logic              cpu_ack,
  input wire logic              low_power,
  input wire logic [12:0]       address_lines,
  input wire logic [7:0]        data_lines_out,
  input wire logic              data_lines_oe,
  input wire logic              chip_select_n,
  input wire logic              read_n,
  input wire logic              write_n,
  input wire logic              data_strobe,
  input wire logic              fetch_status,
  input wire logic              insn_boundary,
  input wire logic              irq_mask,
  input wire logic              irq_n,
  input wire logic              irq_take,
  input wire logic              irq_pending
);
  // ********************
  // decode helpers
  // ********************
  logic tk;
  logic ext;
  logic quiet;
  // window 0x20-0x4f and everything above page zero go external
  assign tk    = cpu_req && cpu_ready;
  assign ext   = (cpu_req_info.addr[12:8] != 5'h00) ||
                 (cpu_req_info.addr[7:0] inside {[8'h20:8'h4F]});
  assign quiet = (cpu_req_info.addr[12:5] == 8'h00) &&
                 IO_UNUSED[cpu_req_info.addr[4:0]];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ********************
  // bus cycle properties
  // ********************
  chk_addr_out: assert property (
    tk |=> address_lines == $past(cpu_req_info.addr))
    else $error("address lines differ from request");
  chk_read_dir: assert property (
    tk |=> read_n == $past(cpu_req_info.write))
    else $error("read direction wrong");
  chk_strobe_ack: assert property (
    tk |=> !data_strobe ##1 data_strobe ##1 cpu_ack)
    else $error("strobe or acknowledge out of place");
  chk_ext_select: assert property (
    tk && ext |=> ##1 !chip_select_n)
    else $error("select missing on external access");
  chk_unused_quiet: assert property (
    tk && quiet |=> chip_select_n [*2])
    else $error("select on unused location");
  chk_write_pulse: assert property (
    tk && ext && cpu_req_info.write |=> write_n ##1 (!write_n &&
    data_lines_oe && data_lines_out == $past(cpu_req_info.wdata, 2)))
    else $error("write strobe or data wrong");
  chk_int_drive: assert property (
    tk && !ext && !quiet && !cpu_req_info.write |=> ##1 data_lines_oe)
    else $error("internal read not driven on bus");
  chk_fetch_flag: assert property (
    tk && cpu_req_info.fetch && !cpu_req_info.write |=> fetch_status)
    else $error("fetch status missing");
  // the strobe keeps its half-rate beat whenever awake
  chk_ds_beat: assert property (
    !low_power && !$past(low_power) && !$past(low_power, 2) &&
    $past(rstn, 2) |-> data_strobe != $past(data_strobe))
    else $error("data strobe stopped toggling");

  // ********************
  // interrupt properties
  // ********************
  chk_irq_take: assert property (
    insn_boundary && irq_pending && !irq_mask |=> irq_take)
    else $error("interrupt not taken");
  chk_irq_cause: assert property (
    irq_take |-> $past(insn_boundary && irq_pending && !irq_mask))
    else $error("interrupt taken without cause");
  chk_irq_latch: assert property (
    $fell(irq_n) |-> ##[1:4] irq_pending)
    else $error("request latch not set");
endmodule

bind eeb_bus_irq eeb_bus_irq_sva #(.IO_UNUSED(IO_UNUSED)) u_sva (
  .clk, .rstn, .cpu_req, .cpu_req_info, .cpu_ready, .cpu_ack,
  .low_power, .address_lines, .data_lines_out, .data_lines_oe,
  .chip_select_n, .read_n, .write_n, .data_strobe, .fetch_status,
  .insn_boundary, .irq_mask, .irq_n, .irq_take, .irq_pending);

// ### verification/eeb_ext_mem.sv
// behavioural external memory on the far side of the bus
// assumes full-pin strobes; the bench resolves the bus level
`timescale 1ns/1ps
module eeb_ext_mem (
  input  wire logic        clk,
  input  wire logic [12:0] address_lines,
  input  wire logic        chip_select_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic [7:0]  bus,
  output logic [7:0]       mem_q
);
  // ********************
  // storage
  // ********************
  logic [7:0] mem [8192];
  logic [7:0] last_q;
  logic       en;
  // preload a pattern so unwritten bytes are predictable
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    last_q = 8'h00;
  end
  // released bus shows the inverse, so stale data never matches
  assign en    = !chip_select_n && !read_n;
  assign mem_q = en ? mem[address_lines] : ~last_q;
  // writes land while the write strobe is low
  always @(posedge clk) begin
    if (!chip_select_n && !write_n) begin
      mem[address_lines] <= bus;
    end
    if (en) begin
      last_q <= mem[address_lines];
    end
  end
endmodule

// ### verification/test_emulator_external_bus_irq.sv
// self-checking bench for the external bus and interrupt front end
// assumes default build parameters and the memory model beside it
`timescale 1ns/1ps
module test_emulator_external_bus_irq;
  // ********************
  // signals
  // ********************
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic [3:0]  k;
    logic [7:0]  exp;
  } eeb_row_t;
  logic              clk, rstn, cpu_req, cpu_ready, cpu_ack, low_power;
  eeb_pkg::eeb_req_t cpu_req_info;
  logic [7:0]        cpu_rdata, data_lines_in, data_lines_out, mem_q;
  logic [12:0]       address_lines;
  logic              data_lines_oe, chip_select_n, read_n, write_n;
  logic              data_strobe, fetch_status, io_write, irq_n;
  logic [4:0]        io_index;
  logic [7:0]        io_wdata, io_rdata;
  logic              insn_boundary, irq_mask, irq_take, irq_pending;
  logic              irq_take_e, irq_pending_e;
  logic [12:0]       io_last = '0;
  int                failures = 0;
  int                n_compared = 0;
  // k: bit0 write, bit1 fetch, bit2 compare read data
  localparam eeb_row_t ROWS [16] = '{
    '{13'h1234, 8'h3C, 4'h1, 8'h00}, '{13'h1234, 8'h00, 4'h4, 8'h3C},
    '{13'h0030, 8'hA6, 4'h1, 8'h00}, '{13'h0030, 8'h00, 4'h4, 8'hA6},
    '{13'h004F, 8'hC3, 4'h1, 8'h00}, '{13'h004F, 8'h00, 4'h4, 8'hC3},
    '{13'h0050, 8'h11, 4'h1, 8'h00}, '{13'h0050, 8'h00, 4'h4, 8'h11},
    '{13'h00FF, 8'h77, 4'h1, 8'h00}, '{13'h00FF, 8'h00, 4'h4, 8'h77},
    '{13'h1FFF, 8'h00, 4'h6, 8'hA5}, '{13'h0100, 8'h00, 4'h4, 8'h5A},
    '{13'h0003, 8'h00, 4'h4, 8'hA3}, '{13'h0006, 8'h00, 4'h4, 8'h00},
    '{13'h0007, 8'h55, 4'h1, 8'h00}, '{13'h0006, 8'h99, 4'h1, 8'h00}};

  // ********************
  // design, partner and bus level
  // ********************
  eeb_bus_irq u_dut (.clk, .rstn, .cpu_req, .cpu_req_info, .cpu_ready,
    .cpu_ack, .cpu_rdata, .low_power, .address_lines, .data_lines_in,
    .data_lines_out, .data_lines_oe, .chip_select_n, .read_n, .write_n,
    .data_strobe, .fetch_status, .io_write, .io_index, .io_wdata,
    .io_rdata, .irq_n, .insn_boundary, .irq_mask, .irq_take,
    .irq_pending);
  // edge-only build beside it, so both sense options are exercised
  eeb_bus_irq #(.EDGE_AND_LEVEL(1'b0)) u_edge (.clk, .rstn, .cpu_req,
    .cpu_req_info, .cpu_ready(), .cpu_ack(), .cpu_rdata(), .low_power,
    .address_lines(), .data_lines_in, .data_lines_out(),
    .data_lines_oe(), .chip_select_n(), .read_n(), .write_n(),
    .data_strobe(), .fetch_status(), .io_write(), .io_index(),
    .io_wdata(), .io_rdata, .irq_n, .insn_boundary, .irq_mask,
    .irq_take(irq_take_e), .irq_pending(irq_pending_e));
  eeb_ext_mem u_mem (.clk, .address_lines, .chip_select_n, .read_n,
    .write_n, .bus(data_lines_in), .mem_q);
  // the device wins the bus while it drives, else the memory model
  assign data_lines_in = data_lines_oe ? data_lines_out : mem_q;
  assign io_rdata      = {3'h5, io_index};

  // remember the last i/o port write seen on the side port
  always @(posedge clk) begin
    if (io_write === 1'h1) begin
      io_last <= {io_index, io_wdata};
    end
  end

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ********************
  // tasks
  // ********************
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until an edge with ready high takes it
  task automatic xfer(input eeb_row_t r, output logic [7:0] d);
    int n;
    n = 0;
    cpu_req_info = '{r.addr, r.wdata, r.k[0], r.k[1]};
    cpu_req = 1'h1;
    while (cpu_ready !== 1'h1 && n < 20) begin
      step();
      n++;
    end
    step();
    cpu_req = 1'h0;
    while (cpu_ack !== 1'h1 && n < 40) begin
      step();
      n++;
    end
    check(8'(cpu_ack), 8'h01);
    d = cpu_rdata;
  endtask
  task automatic pulse();
    insn_boundary = 1'h1;
    step();
    insn_boundary = 1'h0;
  endtask
  task automatic rst_chk();
    check({1'h0, chip_select_n, read_n, write_n, data_strobe, cpu_ack,
           irq_pending, data_lines_oe}, 8'h70);
  endtask
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ********************
  // sequence
  // ********************
  initial begin
    logic [7:0] d;
    rstn = 1'h0;
    cpu_req = 1'h0;
    cpu_req_info = '0;
    low_power = 1'h0;
    irq_n = 1'h1;
    insn_boundary = 1'h0;
    irq_mask = 1'h0;
    repeat (16) @(posedge clk);
    #1;
    rst_chk();
    rstn = 1'h1;
    step();
    foreach (ROWS[i]) begin
      xfer(ROWS[i], d);
      if (ROWS[i].k[2]) check(d, ROWS[i].exp);
    end
    // the used port write lands; the unused slot write does not
    check(io_last[7:0], 8'h55);
    check(8'(io_last[12:8]), 8'h07);
    // asleep: no strobe beat and no new requests
    low_power = 1'h1;
    repeat (4) step();
    d[0] = data_strobe;
    step();
    check(8'(data_strobe), 8'(d[0]));
    check(8'(cpu_ready), 8'h00);
    low_power = 1'h0;
    // masked request stays pending across a boundary
    irq_mask = 1'h1;
    irq_n = 1'h0;
    repeat (5) step();
    check(8'(irq_pending), 8'h01);
    check(8'(irq_pending_e), 8'h01);
    pulse();
    check(8'(irq_take), 8'h00);
    irq_mask = 1'h0;
    pulse();
    check(8'(irq_take), 8'h01);
    check(8'(irq_take_e), 8'h01);
    step();
    check(8'(irq_pending), 8'h01);
    check(8'(irq_pending_e), 8'h00);
    irq_n = 1'h1;
    repeat (4) step();
    pulse();
    check({6'h00, irq_take, irq_pending}, 8'h02);
    // reset in mid-run, then memory contents survive in the model
    rstn = 1'h0;
    repeat (2) step();
    rst_chk();
    rstn = 1'h1;
    step();
    xfer(ROWS[1], d);
    check(d, 8'h3C);
    final_report();
  end

  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule
